// ---- src/flash_ctrl_map.vh ----
// Purpose: register offsets, fields and timing figures of the flash bus controller
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   times in ns; cycle counts derive from the clock period
`ifndef FLASH_CTRL_MAP_VH
`define FLASH_CTRL_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL        12'h000
`define REG_ADDR        12'h004
`define REG_WDATA       12'h008
`define REG_STATUS      12'h00c
`define REG_RDATA       12'h010

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_GO         0
`define CTRL_OP_LO      1
`define CTRL_OP_HI      3
`define CTRL_WIDE       4
`define CTRL_HV_RST     5
`define CTRL_HV_ID      6

// ----------------------------------------
// operations
// ----------------------------------------
`define OP_READ         3'h0
`define OP_WRITE        3'h1
`define OP_RESET_PULSE  3'h2
`define OP_PROT_WRITE   3'h3
`define OP_ID_READ      3'h4

// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_BUSY         0
`define ST_READY        1
`define ST_FAIL         2
`define ST_DONE         3

// ----------------------------------------
// timing, bus widths and fail bit position
// ----------------------------------------
`define CLK_PERIOD_NS   40
`define T_ACCESS_NS     70
`define T_WPULSE_NS     45
`define T_SETUP_NS      40
`define T_RP_NS         500
`define T_READY_NS      20000
`define FAIL_BIT        5
`define DATA_W          16
`define ADDR_W          17

`endif

// ---- src/strobe_timer.v ----
// Purpose: counts a phase of a bus cycle and flags its end
// Assumes: load pulses once per phase
// Notes:   count of zero still gives one cycle
`timescale 1ns/1ns
module strobe_timer #(
	parameter W = 10
) (
	// clock and reset
	input  wire         pclk,
	input  wire         presetn,
	// control
	input  wire         load,
	input  wire [W-1:0] count,
	output wire         expired
);
	reg [W-1:0] remain;
	reg         running;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain  <= {W{1'b0}};
			running <= 1'b0;
		end else if (load) begin
			remain  <= count;
			running <= 1'b1;
		end else if (running && remain != {W{1'b0}}) begin
			remain <= remain - {{(W-1){1'b0}}, 1'b1};
		end else begin
			running <= 1'b0;
		end
	end

	assign expired = running && (remain == {W{1'b0}});
endmodule // strobe_timer

// ---- src/flash_bus_ctrl.v ----
// Purpose: apb-driven master of an asynchronous parallel nor flash bus
// Assumes: flash pins sampled through two flops; high voltages are level-request outputs
// Notes:   at most one bus cycle per go (reset pulse op gives a reset instead); software sequences commands
//
// Contract
// - writes use chip and write enable low with output enable high
// - only software-chosen command values go out; controller never invents commands
// - after fail bit or select mode, software must write reset command
// - hard reset held low longer than minimum pulse time
// - sector protect is a write with high voltage on reset pin, a0 low a1 high a6 low
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "flash_ctrl_map.vh"
module flash_bus_ctrl #(
	parameter RECOVER_CYC = (`T_READY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire                pclk,
	input  wire                presetn,
	// apb slave
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [11:0]         paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output wire                pready,
	output wire                pslverr,
	// flash strobes
	output reg                 chip_enable_n,
	output reg                 output_enable_n,
	output reg                 write_enable_n,
	output reg                 hard_clear_n,
	output reg                 hard_clear_hv,
	output reg                 id_hv_request,
	output reg                 width_select_n,
	// flash address and data
	output reg  [`ADDR_W-1:0]  flash_addr,
	output reg                 top_data_or_byte_lsb_out,
	output reg                 top_data_or_byte_lsb_oe,
	input  wire                top_data_or_byte_lsb_in,
	output reg  [`DATA_W-2:0]  data_out,
	output reg                 data_oe,
	input  wire [`DATA_W-2:0]  data_in,
	input  wire                ready_busy_n
);
	localparam ACC_CYC = (`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
	localparam WP_CYC  = (`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam SU_CYC  = (`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam RP_CYC  = (`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
	localparam TW      = 16;

	localparam S_IDLE  = 3'h0;
	localparam S_SETUP = 3'h1;
	localparam S_PULSE = 3'h2;
	localparam S_HOLD  = 3'h3;
	localparam S_RST   = 3'h4;
	localparam S_RECOV = 3'h5;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [`DATA_W-1:0] din_s1, din_s2;
	reg               rb_s1, rb_s2;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_s1 <= {`DATA_W{1'b0}};
			din_s2 <= {`DATA_W{1'b0}};
			rb_s1  <= 1'b0;
			rb_s2  <= 1'b0;
		end else begin
			din_s1 <= {top_data_or_byte_lsb_in, data_in};
			din_s2 <= din_s1;
			rb_s1  <= ready_busy_n;
			rb_s2  <= rb_s1;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [2:0]         op;
	reg               wide, hv_rst, hv_id, done;
	reg [`ADDR_W-1:0] addr_reg;
	reg [`DATA_W-1:0] wdata_reg, rdata_reg;
	reg [2:0]         state;
	reg               tload;
	reg [TW-1:0]      tcount;
	wire              texp;

	wire wr_en = psel && penable && pwrite;
	wire busy  = (state != S_IDLE);
	wire go    = wr_en && paddr == `REG_CTRL && pwdata[`CTRL_GO] && !busy;

	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op        <= `OP_READ;
			wide      <= 1'b1;
			hv_rst    <= 1'b0;
			hv_id     <= 1'b0;
			addr_reg  <= {`ADDR_W{1'b0}};
			wdata_reg <= {`DATA_W{1'b0}};
		end else if (wr_en) begin
			case (paddr)
			`REG_CTRL: begin
				op     <= pwdata[`CTRL_OP_HI:`CTRL_OP_LO];
				wide   <= pwdata[`CTRL_WIDE];
				hv_rst <= pwdata[`CTRL_HV_RST];
				hv_id  <= pwdata[`CTRL_HV_ID];
			end
			`REG_ADDR:  addr_reg  <= pwdata[`ADDR_W-1:0];
			`REG_WDATA: wdata_reg <= pwdata[`DATA_W-1:0];
			default: ;
			endcase
		end
	end

	always @* begin
		case (paddr)
		`REG_CTRL:   prdata = {25'h0, hv_id, hv_rst, wide, op, 1'b0};
		`REG_ADDR:   prdata = {{(32-`ADDR_W){1'b0}}, addr_reg};
		`REG_WDATA:  prdata = {16'h0, wdata_reg};
		`REG_STATUS: prdata = {28'h0, done, rdata_reg[`FAIL_BIT], rb_s2, busy};
		`REG_RDATA:  prdata = {16'h0, rdata_reg};
		default:     prdata = 32'h0;
		endcase
	end

	// ----------------------------------------
	// bus cycle sequencer
	// ----------------------------------------
	strobe_timer #(.W(TW)) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (tload),
		.count   (tcount),
		.expired (texp)
	);

	wire is_write = (op == `OP_WRITE) || (op == `OP_PROT_WRITE);
	wire is_read  = (op == `OP_READ) || (op == `OP_ID_READ);
	// powered-up controller starts with a hard reset so the device is in read array
	reg  boot;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state           <= S_IDLE;
			boot            <= 1'b1;
			done            <= 1'b0;
			tload           <= 1'b0;
			tcount          <= {TW{1'b0}};
			chip_enable_n   <= 1'b1;
			output_enable_n <= 1'b1;
			write_enable_n  <= 1'b1;
			hard_clear_n    <= 1'b0;
			hard_clear_hv   <= 1'b0;
			id_hv_request   <= 1'b0;
			width_select_n  <= 1'b1;
			flash_addr      <= {`ADDR_W{1'b0}};
			data_out        <= {(`DATA_W-1){1'b0}};
			data_oe         <= 1'b0;
			top_data_or_byte_lsb_out <= 1'b0;
			top_data_or_byte_lsb_oe  <= 1'b0;
			rdata_reg       <= {`DATA_W{1'b0}};
		end else begin
			tload <= 1'b0;
			if (go)
				done <= 1'b0;
			case (state)
			S_IDLE: begin
				hard_clear_hv <= hv_rst;
				id_hv_request <= hv_id;
				if (boot || (go && op == `OP_RESET_PULSE)) begin
					boot         <= 1'b0;
					hard_clear_n <= 1'b0;
					tload        <= 1'b1;
					tcount       <= RP_CYC[TW-1:0];
					state        <= S_RST;
				end else if (go && (is_write || is_read)) begin
					width_select_n <= wide;
					flash_addr     <= addr_reg;
					top_data_or_byte_lsb_out <= wide ? wdata_reg[`DATA_W-1] : addr_reg[0];
					top_data_or_byte_lsb_oe  <= wide ? is_write : 1'b1;
					data_out       <= wdata_reg[`DATA_W-2:0];
					data_oe        <= is_write;
					tload          <= 1'b1;
					tcount         <= SU_CYC[TW-1:0];
					state          <= S_SETUP;
				end else if (go) begin
					done <= 1'b1;
				end
			end
			S_SETUP: if (texp) begin
				chip_enable_n   <= 1'b0;
				output_enable_n <= is_write;
				write_enable_n  <= ~is_write;
				tload           <= 1'b1;
				tcount          <= is_write ? WP_CYC[TW-1:0] : ACC_CYC[TW-1:0];
				state           <= S_PULSE;
			end
			S_PULSE: if (texp) begin
				if (!is_write)
					rdata_reg <= wide ? din_s2 : {8'h0, din_s2[7:0]};
				chip_enable_n   <= 1'b1;
				output_enable_n <= 1'b1;
				write_enable_n  <= 1'b1;
				tload           <= 1'b1;
				tcount          <= SU_CYC[TW-1:0];
				state           <= S_HOLD;
			end
			S_HOLD: if (texp) begin
				data_oe <= 1'b0;
				top_data_or_byte_lsb_oe <= ~wide;
				done  <= 1'b1;
				state <= S_IDLE;
			end
			S_RST: if (texp) begin
				hard_clear_n <= 1'b1;
				tload        <= 1'b1;
				tcount       <= RECOVER_CYC[TW-1:0];
				state        <= S_RECOV;
			end
			// timer expiry is a single pulse; re-arm it while the device still reports busy
			S_RECOV: if (texp) begin
				if (rb_s2) begin
					done  <= 1'b1;
					state <= S_IDLE;
				end else begin
					tload  <= 1'b1;
					tcount <= {TW{1'b0}};
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // flash_bus_ctrl

// ---- verification/flash_bus_ctrl_assertions.sv ----
// Purpose: timing relations on the flash pins of the bus controller
// Assumes: RECOVER_CYC of at least 4
// Notes:   one clock domain, so default clocking and disable
`timescale 1ns/1ns
module flash_bus_ctrl_assertions (
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// flash pins
	input wire        chip_enable_n,
	input wire        output_enable_n,
	input wire        write_enable_n,
	input wire        hard_clear_n,
	input wire        data_oe,
	input wire [14:0] data_out,
	input wire [16:0] flash_addr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// 13 cycles is the shortest pulse that still outlasts the minimum
	sequence s_rp;
		!hard_clear_n[*8] ##1 !hard_clear_n[*5];
	endsequence
	sequence s_acc;
		!output_enable_n[*3];
	endsequence
	property p_rp;
		$fell(hard_clear_n) |-> s_rp;
	endproperty
	a_rp: assert property (p_rp) else $error("reset pulse too short");
	property p_lock;
		!hard_clear_n |-> write_enable_n && chip_enable_n;
	endproperty
	a_lock: assert property (p_lock) else $error("strobe during reset");
	property p_rec;
		$rose(hard_clear_n) |-> chip_enable_n[*4];
	endproperty
	a_rec: assert property (p_rec) else $error("access before recovery");
	property p_wr_oe;
		!write_enable_n |-> output_enable_n;
	endproperty
	a_wr_oe: assert property (p_wr_oe) else $error("write with output enabled");
	property p_bus_free;
		!output_enable_n |-> !data_oe;
	endproperty
	a_bus_free: assert property (p_bus_free) else $error("data driven during read");
	property p_wpulse;
		$fell(write_enable_n) |-> !write_enable_n[*2];
	endproperty
	a_wpulse: assert property (p_wpulse) else $error("write pulse too short");
	property p_rdpulse;
		$fell(output_enable_n) |-> s_acc;
	endproperty
	a_rdpulse: assert property (p_rdpulse) else $error("read pulse too short");
	property p_apos;
		!write_enable_n |-> $stable(flash_addr);
	endproperty
	a_apos: assert property (p_apos) else $error("address moved in write");
	property p_dhold;
		$rose(write_enable_n) |-> data_oe && $stable(data_out);
	endproperty
	a_dhold: assert property (p_dhold) else $error("data not held at rise");
endmodule // flash_bus_ctrl_assertions
bind flash_bus_ctrl flash_bus_ctrl_assertions chk (.pclk, .presetn, .chip_enable_n, .output_enable_n,
	.write_enable_n, .hard_clear_n, .data_oe, .data_out, .flash_addr);

// ---- verification/flash_model.sv ----
// Purpose: behavioural parallel nor flash
// Assumes: word mode; coarse sectors on a[16:14]; 256-word array
// Notes:   program makes the device busy for BUSY_NS
`timescale 1ns/1ns
module flash_model #(
	parameter [15:0] MAKER   = 16'h005a, // arbitrary value
	parameter [15:0] PART    = 16'h2a3c, // arbitrary value
	parameter        BUSY_NS = 400
) (
	// strobes
	input wire        ce_n,
	input wire        oe_n,
	input wire        we_n,
	input wire        rst_n,
	input wire        rst_hv,
	input wire        id_hv,
	// address and data
	input wire [16:0] a,
	input wire [15:0] d,
	output wire [15:0] q,
	output wire       q_en,
	output reg        rb_n
);
	reg [15:0] mem [0:255];
	reg [7:0]  prot;
	reg [1:0]  st;
	reg        id;
	reg [16:0] la;
	time       tf;
	integer    i;
	wire wr = !ce_n && !we_n && oe_n;
	assign q_en = !ce_n && !oe_n && rst_n;
	assign q = id || id_hv ? (a[1] ? {15'h0, prot[a[16:14]]} : a[0] ? PART : MAKER)
		: mem[a[7:0]];
	initial begin
		prot = 8'h00;
		st = 0;
		id = 0;
		rb_n = 1;
		for (i = 0; i < 256; i = i + 1) mem[i] = 16'hffff;
	end
	always @(negedge rst_n) begin
		st = 0;
		id = 0;
		// a cut operation keeps the device busy for a while before read array
		if (!rb_n) rb_n <= #BUSY_NS 1'b1;
	end
	always @(posedge wr) begin
		la = a;
		tf = $time;
	end
	// short pulses and writes under reset never reach the decoder
	always @(negedge wr) if (rst_n && $time - tf >= 5) begin
		if (st == 3) begin
			if (!prot[la[16:14]] || rst_hv) mem[la[7:0]] = d;
			st = 0;
			rb_n = 0;
			rb_n <= #BUSY_NS 1'b1;
		end else if (rst_hv && st == 0 && la[1] && !la[0]) begin
			if (la[6]) prot = 0;
			else prot[la[16:14]] = 1;
		end else if (d[7:0] == 8'hb0 && !rb_n) begin
			rb_n = 1;
		end else if (d[7:0] == 8'hf0 && rb_n) begin
			st = 0;
			id = 0;
		end else if (d[7:0] == 8'haa) st = 1;
		else if (st == 1 && d[7:0] == 8'h55) st = 2;
		else if (st == 2) begin
			id = d[7:0] == 8'h90;
			st = d[7:0] == 8'ha0 ? 3 : 0;
		end
	end
endmodule // flash_model

// ---- verification/flash_bus_ctrl_tb.sv ----
// Purpose: self-checking bench of the flash bus controller
// Assumes: word mode; recovery cut to 4 cycles
// Notes:   reference array and protection kept here
`timescale 1ns/1ns
`include "flash_ctrl_map.vh"
module flash_bus_ctrl_tb;
	localparam [15:0] MK = 16'h005a; // arbitrary value
	localparam [15:0] PT = 16'h2a3c; // arbitrary value
	reg pclk, presetn, psel, penable, pwrite;
	reg [11:0] paddr;
	reg [31:0] pwdata, seed, r;
	reg [7:0] prot;
	reg [15:0] ref_mem [0:255];
	integer fails, comparisons, t, i;
	wire [31:0] prdata;
	wire pready, chip_enable_n, output_enable_n, write_enable_n, hard_clear_n, hard_clear_hv, id_hv_request;
	wire top_data_or_byte_lsb_out, top_data_or_byte_lsb_oe, data_oe, ready_busy_n, q_en;
	wire pslverr, width_select_n;
	wire [16:0] flash_addr;
	wire [14:0] data_out;
	wire [15:0] q;
	// undriven lines show the inverse so a stale value cannot pass
	wire [15:0] bus = {top_data_or_byte_lsb_oe ? top_data_or_byte_lsb_out : q_en ? q[15] : ~top_data_or_byte_lsb_out,
		data_oe ? data_out : q_en ? q[14:0] : ~data_out};
	flash_bus_ctrl #(.RECOVER_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .chip_enable_n, .output_enable_n, .write_enable_n, .hard_clear_n, .hard_clear_hv,
		.id_hv_request, .width_select_n, .flash_addr, .top_data_or_byte_lsb_out, .top_data_or_byte_lsb_oe,
		.top_data_or_byte_lsb_in(bus[15]), .data_out, .data_oe, .data_in(bus[14:0]), .ready_busy_n);
	flash_model #(.MAKER(MK), .PART(PT)) mdl (.ce_n(chip_enable_n), .oe_n(output_enable_n),
		.we_n(write_enable_n), .rst_n(hard_clear_n), .rst_hv(hard_clear_hv), .id_hv(id_hv_request),
		.a(flash_addr), .d(bus), .q, .q_en, .rb_n(ready_busy_n));
	function [31:0] xs(input [31:0] s);
		reg [31:0] v;
		begin
			v = s ^ (s << 13);
			v = v ^ (v >> 17);
			xs = v ^ (v << 5);
		end
	endfunction
	function [15:0] ev(input [16:0] a);
		ev = ref_mem[a[7:0]];
	endfunction
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task chk(input [31:0] e, input [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// levels first, go second, so high voltage settles before the strobes
	task run(input [2:0] op, input [16:0] a, input [15:0] d, input [1:0] hv);
		apb(1, `REG_ADDR, a);
		apb(1, `REG_WDATA, d);
		apb(1, `REG_CTRL, {hv, 1'b1, op, 1'b0});
		apb(1, `REG_CTRL, {hv, 1'b1, op, 1'b1});
		// fail bit mirrors the last read word, so it is left out of the wait
		do apb(0, `REG_STATUS, 0); while ((r[3:0] & 4'b1011) !== 4'b1010);
		apb(0, `REG_RDATA, 0);
	endtask
	task prog(input [16:0] a, input [15:0] d, input [1:0] hv);
		run(`OP_WRITE, 17'h555, 16'haa, hv);
		run(`OP_WRITE, 17'h2aa, 16'h55, hv);
		run(`OP_WRITE, 17'h555, 16'ha0, hv);
		run(`OP_WRITE, a, d, hv);
		if (!prot[a[16:14]] || hv[0]) ref_mem[a[7:0]] = d;
	endtask
	task rd(input [16:0] a, input [1:0] hv, input [15:0] e);
		run(`OP_READ, a, 0, hv);
		chk({16'h0, e}, r);
	endtask
	task nxt;
		$display("test %0d done", t);
		t = t + 1;
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		#800000;
		fails = fails + 1;
		wrap_up;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, prot, fails, comparisons} = 0;
		seed = 14290;
		t = 1;
		for (i = 0; i < 256; i = i + 1) ref_mem[i] = 16'hffff;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		do apb(0, `REG_STATUS, 0); while (r[1:0] !== 2'b10);
		apb(0, `REG_CTRL, 0);
		chk(32'h10, r);
		apb(0, 12'h020, 0);
		chk(0, r);
		chk(0, {31'h0, pslverr});
		rd(17'h12, 0, 16'hffff);
		chk(32'h1, {31'h0, width_select_n});
		nxt;
		for (i = 0; i < 4; i = i + 1) begin
			seed = xs(seed);
			prog(seed[16:0], seed[31:16], 0);
			rd(seed[16:0], 0, ev(seed[16:0]));
		end
		nxt;
		rd(17'h14002, 2'b10, 16'h0);
		run(`OP_PROT_WRITE, 17'h14002, 0, 2'b01);
		prot[5] = 1;
		rd(17'h14002, 2'b10, 16'h1);
		prog(17'h14010, 16'h1234, 0);
		rd(17'h14010, 0, ev(17'h14010));
		prog(17'h14010, 16'h1234, 2'b01);
		rd(17'h14010, 0, 16'h1234);
		run(`OP_PROT_WRITE, 17'h00042, 0, 2'b01);
		prot = 0;
		rd(17'h14002, 2'b10, 16'h0);
		rd(17'h0, 2'b10, MK);
		rd(17'h1, 2'b10, PT);
		nxt;
		run(`OP_WRITE, 17'h555, 16'haa, 0);
		run(`OP_WRITE, 17'h2aa, 16'h55, 0);
		run(`OP_WRITE, 17'h555, 16'h90, 0);
		rd(17'h0, 0, MK);
		rd(17'h1, 0, PT);
		run(`OP_WRITE, 17'h0, 16'hf0, 0);
		rd(17'h14010, 0, 16'h1234);
		run(`OP_WRITE, 17'h555, 16'haa, 0);
		run(`OP_WRITE, 17'h2aa, 16'h55, 0);
		run(`OP_WRITE, 17'h555, 16'h90, 0);
		run(`OP_RESET_PULSE, 0, 0, 0);
		rd(17'h14010, 0, 16'h1234);
		nxt;
		wrap_up;
	end
endmodule // flash_bus_ctrl_tb
